// ---- sscb_pkg.sv ----
package sscb_pkg;
    localparam int WORD_W = 22;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] WORD_BITS = 5'h16;
    localparam int ADDR_HI = 1;
    localparam int ADDR_LO = 0;

    typedef enum logic [1:0] {
        SSCB_ADDR_IF_REF = 2'b00,
        SSCB_ADDR_RF_REF = 2'b01,
        SSCB_ADDR_IF_FB = 2'b10,
        SSCB_ADDR_RF_FB = 2'b11
    } sscb_addr_t;

    // word 00 fields
    localparam int IFPUMP_HI = 3;
    localparam int IFPUMP_LO = 2;
    localparam int LDSEL_HI = 6;
    localparam int LDSEL_LO = 4;
    localparam int IFREF_HI = 19;
    localparam int IFREF_LO = 7;
    localparam int DITH_HI = 21;
    localparam int DITH_LO = 20;
    localparam logic [1:0] DITH_ON = 2'b10;
    localparam logic [1:0] DITH_OFF = 2'b11;
    // word 01 fields
    localparam int RFPOL_BIT = 2;
    localparam int RFPUMP_HI = 4;
    localparam int RFPUMP_LO = 3;
    localparam int PSEL_BIT = 5;
    localparam int RFREF_HI = 8;
    localparam int RFREF_LO = 6;
    localparam int MEXT_HI = 21;
    localparam int MEXT_LO = 9;
    // word 10 fields
    localparam int IFPOL_BIT = 2;
    localparam int EN_HI = 4;
    localparam int EN_LO = 3;
    localparam int IFFB_HI = 21;
    localparam int IFFB_LO = 5;
    // word 11 fields
    localparam int FRAC_HI = 9;
    localparam int FRAC_LO = 2;
    localparam int RFINT_HI = 21;
    localparam int RFINT_LO = 10;

    typedef enum logic [2:0] {
        SSCB_LD_IF_N = 3'b000,
        SSCB_LD_IF_R = 3'b001,
        SSCB_LD_IF_LOCK = 3'b010,
        SSCB_LD_RF_N = 3'b011,
        SSCB_LD_RF_R = 3'b100,
        SSCB_LD_RF_LOCK = 3'b101,
        SSCB_LD_LOW = 3'b110,
        SSCB_LD_HIGH = 3'b111
    } sscb_ld_sel_t;

    localparam logic [WORD_W-1:0] WORD00_RST = 22'h00_0000;
    localparam logic [WORD_W-1:0] WORD01_RST = 22'h00_0000;
    localparam logic [WORD_W-1:0] WORD10_RST = 22'h00_0018;
    localparam logic [WORD_W-1:0] WORD11_RST = 22'h00_0000;
    localparam logic [1:0] EN_BOTH = 2'b11;
endpackage : sscb_pkg

// ---- sscb_serial_bank.sv ----
// What this block does
// - strobe rise commits word to addressed register
// - strobe rise during clock high discards word
// - words shift most significant bit first
// - four registers written independently, others untouched
// - lock-detect select lives in word 00
// - word 00 bits 21:20 control dithering
// - prescaler select chooses RF 8/9 or 16/17
// - RF feedback divider ratio range per prescaler
// - IF feedback divider is 17 bits
// - RF reference 1..7, IF reference 1..8191
// - charge-pump currents selected by fields
// - charge pump has programmable high impedance
// - lock-detect pin multiplexes dividers or detectors
// - lock selected: low unlocked, high locked
// - power enables per synth, both on default
// - word 11 bits 9:2 binary fraction
// - word 01 bits 21:9 extend fraction
// - effective ratio adds 3.5 offset
// - word 00 bits 3:2 select IF current
`timescale 1ns/1ps
`default_nettype none
module sscb_serial_bank
    import sscb_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic i_serial_clk,
    input wire logic i_serial_in,
    input wire logic i_latch_strobe,
    input wire logic i_if_ndiv,
    input wire logic i_if_rdiv,
    input wire logic i_if_lock,
    input wire logic i_rf_ndiv,
    input wire logic i_rf_rdiv,
    input wire logic i_rf_lock,
    output logic o_lock_detect_out,
    output logic [1:0] o_if_pump_current_sel,
    output logic [1:0] o_rf_pump_current_sel,
    output logic o_if_pump_polarity_sel,
    output logic o_rf_pump_polarity_sel,
    output logic o_if_pump_hiz,
    output logic o_rf_pump_hiz,
    output logic o_prescaler_select,
    output logic [11:0] o_rf_integer_divider,
    output logic [7:0] o_rf_fraction_field,
    output logic [12:0] o_modulo_extender_field,
    output logic [2:0] o_rf_reference_divider,
    output logic [12:0] o_if_reference_divider,
    output logic [16:0] o_if_feedback_divider,
    output logic o_if_power_en,
    output logic o_rf_power_en,
    output logic o_dither_en
);

    // link domain: shift register and bit count on the serial clock
    logic [WORD_W-1:0] shift;
    logic [CNT_W-1:0] bit_cnt;
    logic cnt_over;

    always_ff @(posedge i_serial_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            shift <= '0;
        end else if (!i_latch_strobe) begin
            shift <= {shift[WORD_W-2:0], i_serial_in};
        end
    end

    // count restarts when the strobe falls; async clear by strobe high
    always_ff @(posedge i_serial_clk or posedge i_latch_strobe) begin
        if (i_latch_strobe) begin
            bit_cnt <= '0;
        end else if (bit_cnt != WORD_BITS) begin
            bit_cnt <= bit_cnt + 5'h0_001;
        end
    end

    always_ff @(posedge i_serial_clk or posedge i_latch_strobe) begin
        if (i_latch_strobe) begin
            cnt_over <= 1'b0;
        end else if (bit_cnt == WORD_BITS) begin
            cnt_over <= 1'b1;
        end
    end

    // word captured at strobe rise; commit follows later in the system domain
    logic [WORD_W-1:0] held_word;
    logic held_ok;
    logic held_tgl;

    always_ff @(posedge i_latch_strobe or negedge i_arst_n) begin
        if (!i_arst_n) begin
            held_word <= '0;
        end else begin
            held_word <= shift;
        end
    end

    always_ff @(posedge i_latch_strobe or negedge i_arst_n) begin
        if (!i_arst_n) begin
            held_ok <= 1'b0;
        end else begin
            held_ok <= (bit_cnt == WORD_BITS) && !cnt_over && !i_serial_clk;
        end
    end

    // toggle, not level: the strobe may stay high after the last word
    always_ff @(posedge i_latch_strobe or negedge i_arst_n) begin
        if (!i_arst_n) begin
            held_tgl <= 1'b0;
        end else begin
            held_tgl <= ~held_tgl;
        end
    end

    // system domain: toggle crossing, then commit
    logic tgl_s1;
    logic tgl_s2;
    logic tgl_s3;
    logic [CNT_W-1:0] tgl_dly;

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            tgl_s1 <= 1'b0;
            tgl_s2 <= 1'b0;
            tgl_s3 <= 1'b0;
        end else begin
            tgl_s1 <= held_tgl;
            tgl_s2 <= tgl_s1;
            tgl_s3 <= tgl_s2;
        end
    end

    wire commit = tgl_s2 ^ tgl_s3;
    wire [1:0] waddr = {held_word[ADDR_HI], held_word[ADDR_LO]};

    logic [WORD_W-1:0] word00;
    logic [WORD_W-1:0] word01;
    logic [WORD_W-1:0] word10;
    logic [WORD_W-1:0] word11;

    // one store per word, so a write touches only its own word
    function automatic logic word_hit(input logic [1:0] addr, input sscb_addr_t sel);
        return addr == sel;
    endfunction : word_hit

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            word00 <= WORD00_RST;
        end else if (commit && held_ok && word_hit(waddr, SSCB_ADDR_IF_REF)) begin
            word00 <= held_word;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            word01 <= WORD01_RST;
        end else if (commit && held_ok && word_hit(waddr, SSCB_ADDR_RF_REF)) begin
            word01 <= held_word;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            word10 <= WORD10_RST;
        end else if (commit && held_ok && word_hit(waddr, SSCB_ADDR_IF_FB)) begin
            word10 <= held_word;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            word11 <= WORD11_RST;
        end else if (commit && held_ok && word_hit(waddr, SSCB_ADDR_RF_FB)) begin
            word11 <= held_word;
        end
    end

    // divider and detector inputs are asynchronous
    logic [5:0] mon_s1;
    logic [5:0] mon_s2;

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            mon_s1 <= '0;
            mon_s2 <= '0;
        end else begin
            mon_s1 <= {i_rf_lock, i_rf_rdiv, i_rf_ndiv, i_if_lock, i_if_rdiv, i_if_ndiv};
            mon_s2 <= mon_s1;
        end
    end

    function automatic logic ld_mux(input logic [2:0] sel, input logic [5:0] src);
        logic r;
        r = 1'b0;
        unique case (sel)
            SSCB_LD_IF_N: r = src[0];
            SSCB_LD_IF_R: r = src[1];
            SSCB_LD_IF_LOCK: r = src[2];
            SSCB_LD_RF_N: r = src[3];
            SSCB_LD_RF_R: r = src[4];
            SSCB_LD_RF_LOCK: r = src[5];
            SSCB_LD_LOW: r = 1'b0;
            SSCB_LD_HIGH: r = 1'b1;
        endcase
        return r;
    endfunction : ld_mux

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_lock_detect_out <= 1'b0;
        end else begin
            o_lock_detect_out <= ld_mux(word00[LDSEL_HI:LDSEL_LO], mon_s2);
        end
    end

    // field outputs, registered from the word store
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_if_pump_current_sel <= '0;
        end else begin
            o_if_pump_current_sel <= word00[IFPUMP_HI:IFPUMP_LO];
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rf_pump_current_sel <= '0;
        end else begin
            o_rf_pump_current_sel <= word01[RFPUMP_HI:RFPUMP_LO];
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rf_pump_polarity_sel <= 1'b0;
        end else begin
            o_rf_pump_polarity_sel <= word01[RFPOL_BIT];
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_if_pump_polarity_sel <= 1'b0;
        end else begin
            o_if_pump_polarity_sel <= word10[IFPOL_BIT];
        end
    end

    // pump high impedance while its synthesizer is disabled
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_if_pump_hiz <= 1'b0;
        end else begin
            o_if_pump_hiz <= !word10[EN_LO];
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rf_pump_hiz <= 1'b0;
        end else begin
            o_rf_pump_hiz <= !word10[EN_HI];
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_prescaler_select <= 1'b0;
        end else begin
            o_prescaler_select <= word01[PSEL_BIT];
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rf_integer_divider <= '0;
        end else begin
            o_rf_integer_divider <= word11[RFINT_HI:RFINT_LO];
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rf_fraction_field <= '0;
        end else begin
            o_rf_fraction_field <= word11[FRAC_HI:FRAC_LO];
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_modulo_extender_field <= '0;
        end else begin
            o_modulo_extender_field <= word01[MEXT_HI:MEXT_LO];
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rf_reference_divider <= '0;
        end else begin
            o_rf_reference_divider <= word01[RFREF_HI:RFREF_LO];
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_if_reference_divider <= '0;
        end else begin
            o_if_reference_divider <= word00[IFREF_HI:IFREF_LO];
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_if_feedback_divider <= '0;
        end else begin
            o_if_feedback_divider <= word10[IFFB_HI:IFFB_LO];
        end
    end

    // both synthesizers come up enabled
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_if_power_en <= 1'b1;
        end else begin
            o_if_power_en <= word10[EN_LO];
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rf_power_en <= 1'b1;
        end else begin
            o_rf_power_en <= word10[EN_HI];
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_dither_en <= 1'b0;
        end else begin
            o_dither_en <= (word00[DITH_HI:DITH_LO] == DITH_ON);
        end
    end

endmodule : sscb_serial_bank
`default_nettype wire

// ---- sscb_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module sscb_host_model (
    output logic o_serial_clk,
    output logic o_serial_in,
    output logic o_latch_strobe
);
    initial begin
        o_serial_clk = 1'b0;
        o_serial_in = 1'b0;
        o_latch_strobe = 1'b1;
    end
    // link clock runs inside a frame; with hi set it falls only after the strobe rises
    task automatic send(input logic [21:0] w, input int nb, input logic hi, input logic lat);
        o_latch_strobe = 1'b0;
        #10;
        for (int i = nb - 1; i >= 0; i--) begin
            o_serial_in = (i < 22) ? w[i] : 1'b1;
            #7.5 o_serial_clk = 1'b1;
            #7.5 o_serial_clk = (i == 0) && hi;
        end
        #5 o_latch_strobe = lat;
        #10 o_serial_clk = 1'b0;
        o_serial_in = ~o_serial_in;
    endtask : send
endmodule : sscb_host_model
`default_nettype wire

// ---- sscb_serial_bank_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module sscb_serial_bank_properties
    import sscb_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic i_latch_strobe,
    input wire logic i_if_ndiv,
    input wire logic i_if_rdiv,
    input wire logic i_if_lock,
    input wire logic i_rf_ndiv,
    input wire logic i_rf_rdiv,
    input wire logic i_rf_lock,
    input wire logic o_lock_detect_out,
    input wire logic o_if_pump_hiz,
    input wire logic o_rf_pump_hiz,
    input wire logic o_if_power_en,
    input wire logic o_rf_power_en,
    input wire logic o_dither_en,
    input wire logic [1:0] o_if_pump_current_sel,
    input wire logic [11:0] o_rf_integer_divider,
    input wire logic [16:0] o_if_feedback_divider
);
    logic le_q;
    logic [3:0] since_le;
    wire logic [5:0] src = {i_rf_lock, i_rf_rdiv, i_rf_ndiv, i_if_lock, i_if_rdiv, i_if_ndiv};
    // cycles since strobe rise or reset, saturating
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            le_q <= 1'b1;
            since_le <= 4'h0;
        end else begin
            le_q <= i_latch_strobe;
            if (i_latch_strobe && !le_q) begin
                since_le <= 4'h0;
            end else if (since_le != 4'hF) begin
                since_le <= since_le + 4'h1;
            end
        end
    end
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_arst_n);
    sequence quiet_s;
        since_le >= 4'h8;
    endsequence
    sequence src_still_s;
        (since_le >= 4'h8 && $stable(src))[*6];
    endsequence
    rst_power_a: assert property ($rose(i_arst_n) |-> o_if_power_en && o_rf_power_en)
        else $error("power enables not on after reset");
    rst_dither_a: assert property ($rose(i_arst_n) |-> !o_dither_en)
        else $error("dither on after reset");
    if_hiz_a: assert property (o_if_pump_hiz == !o_if_power_en)
        else $error("if pump hiz mismatch");
    rf_hiz_a: assert property (o_rf_pump_hiz == !o_rf_power_en)
        else $error("rf pump hiz mismatch");
    hold_div_a: assert property (quiet_s |-> $stable(o_rf_integer_divider)
        && $stable(o_if_feedback_divider)) else $error("divider changed without strobe");
    hold_dither_a: assert property (quiet_s |-> $stable({o_dither_en, o_if_pump_current_sel}))
        else $error("word00 field changed without strobe");
    hold_power_a: assert property (quiet_s |-> $stable({o_if_power_en, o_rf_power_en}))
        else $error("power changed without strobe");
    ld_still_a: assert property (src_still_s |-> $stable(o_lock_detect_out))
        else $error("lock detect moved with quiet sources");
endmodule : sscb_serial_bank_properties
bind sscb_serial_bank sscb_serial_bank_properties chk_u (.*);
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
    import sscb_pkg::*;
    logic i_clk_sys = 1'b0;
    logic i_arst_n = 1'b0;
    logic [5:0] src = 6'h00;
    logic i_serial_clk, i_serial_in, i_latch_strobe;
    wire logic i_if_ndiv = src[0], i_if_rdiv = src[1], i_if_lock = src[2];
    wire logic i_rf_ndiv = src[3], i_rf_rdiv = src[4], i_rf_lock = src[5];
    logic o_lock_detect_out, o_if_pump_polarity_sel, o_rf_pump_polarity_sel, o_if_pump_hiz;
    logic o_rf_pump_hiz, o_prescaler_select, o_if_power_en, o_rf_power_en, o_dither_en;
    logic [1:0] o_if_pump_current_sel, o_rf_pump_current_sel;
    logic [11:0] o_rf_integer_divider;
    logic [7:0] o_rf_fraction_field;
    logic [12:0] o_modulo_extender_field, o_if_reference_divider;
    logic [2:0] o_rf_reference_divider;
    logic [16:0] o_if_feedback_divider;
    int bad_count = 0;
    int n_checks = 0;
    always #12.5 i_clk_sys = ~i_clk_sys;
    sscb_host_model host_u (.o_serial_clk(i_serial_clk), .o_serial_in(i_serial_in),
        .o_latch_strobe(i_latch_strobe));
    sscb_serial_bank dut_u (.*);
    task automatic chk(input string nm, input logic [21:0] seen, input logic [21:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic print_verdict;
        if (bad_count == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : print_verdict
    // settle time covers commit latency and word spacing
    task automatic wr(input logic [21:0] w, input int nb = 22, input logic hi = 0,
        input logic lat = 1);
        host_u.send(w, nb, hi, lat);
        #300;
    endtask : wr
    task automatic t_words;
        wr({DITH_ON, 13'h1ABC, SSCB_LD_HIGH, 2'b11, SSCB_ADDR_IF_REF});
        chk("dither", o_dither_en, 1);
        chk("ifref", o_if_reference_divider, 13'h1ABC);
        chk("ifcur", o_if_pump_current_sel, 2'b11);
        chk("ld", o_lock_detect_out, 1);
        chk("n1", o_rf_integer_divider, 0);
        wr({12'd301, 8'd134, SSCB_ADDR_RF_FB});
        chk("n1", o_rf_integer_divider, 12'd301);
        chk("fn", o_rf_fraction_field, 8'd134);
        chk("ifref", o_if_reference_divider, 13'h1ABC);
        wr({13'd3276, 3'd3, 1'b1, 2'b10, 1'b1, SSCB_ADDR_RF_REF});
        chk("me", o_modulo_extender_field, 13'd3276);
        chk("r1", o_rf_reference_divider, 3'd3);
        chk("ps", o_prescaler_select, 1);
        chk("rfcur", {o_rf_pump_current_sel, o_rf_pump_polarity_sel}, 3'b101);
        wr({17'h1FFFF, 2'b01, 1'b1, SSCB_ADDR_IF_FB});
        chk("n2", o_if_feedback_divider, 17'h1FFFF);
        chk("en", {o_rf_power_en, o_if_power_en, o_if_pump_polarity_sel}, 3'b011);
        chk("hiz", {o_rf_pump_hiz, o_if_pump_hiz}, 2'b10);
    endtask : t_words
    task automatic t_lock;
        for (int k = 0; k < 6; k++) begin
            wr({DITH_OFF, 13'h0001, 3'(k), 2'b00, SSCB_ADDR_IF_REF});
            @(posedge i_clk_sys) src <= 6'h01 << k;
            #150 chk("ld_hi", o_lock_detect_out, 1);
            @(posedge i_clk_sys) src <= 6'h00;
            #150 chk("ld_lo", o_lock_detect_out, 0);
        end
        chk("dither", o_dither_en, 0);
    endtask : t_lock
    task automatic t_refuse;
        wr({12'd77, 8'd5, SSCB_ADDR_RF_FB}, 21);
        wr({12'd77, 8'd5, SSCB_ADDR_RF_FB}, 23);
        chk("n1_len", o_rf_integer_divider, 12'd301);
        wr({12'd77, 8'd5, SSCB_ADDR_RF_FB}, 22, 1);
        chk("n1_clkhi", o_rf_integer_divider, 12'd301);
        wr({12'd77, 8'd5, SSCB_ADDR_RF_FB}, 22, 0, 0);
        chk("n1_nolatch", o_rf_integer_divider, 12'd301);
    endtask : t_refuse
    initial begin
        #200000;
        bad_count++;
        print_verdict();
    end
    initial begin
        repeat (2) @(posedge i_clk_sys);
        i_arst_n <= 1'b1;
        #100;
        chk("rst_en", {o_rf_power_en, o_if_power_en, o_dither_en}, 3'b110);
        t_words();
        t_lock();
        t_refuse();
        print_verdict();
    end
endmodule : tb
`default_nettype wire
